//--- dbsws_pkg.sv
package dbsws_pkg;

	// Array geometry: 128K words of 8 data bits plus one parity bit
	localparam int ADDR_W     = 17;
	localparam int BYTE_W     = 8;
	localparam int WORD_W     = 9;
	localparam int ARRAY_SIZE = 131072;

	// Write buffer between the bus capture and the self-timed array write
	localparam int FIFO_DEPTH = 16;
	localparam int ENTRY_W    = ADDR_W + WORD_W;

	// Clock and self-timed write occupancy of the array
	localparam int CLK_PERIOD_NS = 10;
	localparam int WRITE_TIME_NS = 16;
	localparam int WRITE_CYCLES_RAW = (WRITE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int WRITE_CYCLES = (WRITE_CYCLES_RAW < 1) ? 1 : WRITE_CYCLES_RAW;
	localparam int BUSY_W       = 3;
	localparam logic [BUSY_W-1:0] BUSY_LOAD = BUSY_W'(WRITE_CYCLES - 1);
	localparam logic [BUSY_W-1:0] BUSY_ZERO = 3'h0;

	// Reset values of the output side
	localparam logic [WORD_W-1:0] WORD_RESET = 9'h000;

	// Write engine states
	typedef enum logic [1:0] {
		WR_IDLE = 2'h1,
		WR_BUSY = 2'h2
	} dbsws_wr_e;

endpackage

//--- dbsws_fifo.sv
`timescale 1ns/1ps
module dbsws_fifo #(
	parameter int WIDTH = 26,
	parameter int DEPTH = 16
) (
	input  wire logic             clk,      // Core clock
	input  wire logic             rst,      // Asynchronous reset, active high
	input  wire logic             inValid,  // Entry offered
	output logic                  inReady,  // Room for an entry, registered
	input  wire logic [WIDTH-1:0] inData,   // Entry to store
	output logic                  outValid, // Head entry present, registered
	input  wire logic             outReady, // Drain takes the head entry
	output logic      [WIDTH-1:0] outData   // Head entry
);

	localparam int PTR_W = $clog2(DEPTH);
	localparam int CNT_W = $clog2(DEPTH + 1);
	localparam logic [PTR_W-1:0] PTR_LAST = PTR_W'(DEPTH - 1);
	localparam logic [CNT_W-1:0] CNT_FULL = CNT_W'(DEPTH);

	logic [WIDTH-1:0] store [DEPTH];
	logic [PTR_W-1:0] wrPtr;
	logic [PTR_W-1:0] rdPtr;
	logic [CNT_W-1:0] count;
	logic [PTR_W-1:0] next_wrPtr;
	logic [PTR_W-1:0] next_rdPtr;
	logic [CNT_W-1:0] next_count;
	logic             next_inReady;
	logic             next_outValid;
	logic             push;
	logic             pop;

	// Pointer and level bookkeeping; flags are registered so the source sees a clean ready
	always_comb begin
		push       = inValid & inReady;
		pop        = outValid & outReady;
		next_wrPtr = wrPtr;
		next_rdPtr = rdPtr;
		if (push) begin
			next_wrPtr = (wrPtr == PTR_LAST) ? '0 : PTR_W'(wrPtr + 1'b1);
		end
		if (pop) begin
			next_rdPtr = (rdPtr == PTR_LAST) ? '0 : PTR_W'(rdPtr + 1'b1);
		end
		next_count = count;
		if (push && !pop) begin
			next_count = CNT_W'(count + 1'b1);
		end else if (pop && !push) begin
			next_count = CNT_W'(count - 1'b1);
		end
		next_inReady  = (next_count != CNT_FULL);
		next_outValid = (next_count != '0);
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			wrPtr    <= '0;
			rdPtr    <= '0;
			count    <= '0;
			inReady  <= 1'b1;
			outValid <= 1'b0;
		end else begin
			wrPtr    <= next_wrPtr;
			rdPtr    <= next_rdPtr;
			count    <= next_count;
			inReady  <= next_inReady;
			outValid <= next_outValid;
		end
	end

	// Storage carries no reset; only valid entries are ever read out
	always_ff @(posedge clk) begin
		if (push) begin
			store[wrPtr] <= inData;
		end
	end

	assign outData = store[rdPtr];

endmodule

//--- dbsws_sram.sv
// Operation
// - Array write when write strobe low with at least one input enable low at edge.
// - Control, address and data are all sampled on the one clock edge.
// - Data outputs only change just after the rising edge, held otherwise.
// - Strobe low with both input enables high floats both data buses.
// - Streaming write stores one bus's word and drives it onto the other bus.
// - Each bus output enable decides whether that bus is driven, except that a float cycle turns both buses off.
// - Output turn-off is faster than turn-on, so buses never overlap.
// - Strobe high reads the addressed word onto enabled buses.
// - Stream cycle without write passes captured word to the other bus.
`timescale 1ns/1ps
module dbsws_sram (
	input  wire logic                          clk,                 // Core clock, 100 MHz
	input  wire logic                          rst,                 // Async reset, active high
	input  wire logic [dbsws_pkg::ADDR_W-1:0]  addr,                // Word address
	input  wire logic                          writeStrobeN,        // Write strobe, active low
	input  wire logic                          procInputEnableN,    // Capture processor bus, low
	input  wire logic                          sysInputEnableN,     // Capture system bus, low
	input  wire logic                          procOutputEnableN,   // Drive processor bus, low
	input  wire logic                          sysOutputEnableN,    // Drive system bus, low
	input  wire logic [dbsws_pkg::BYTE_W-1:0]  procDataBusIn,       // Processor data pins in
	input  wire logic                          procParityLineIn,    // Processor parity pin in
	output logic      [dbsws_pkg::BYTE_W-1:0]  procDataBusOut,      // Processor data pins out
	output logic                               procParityLineOut,   // Processor parity pin out
	output logic                               procDriveEn,         // Processor pins driven
	input  wire logic [dbsws_pkg::BYTE_W-1:0]  sysDataBusIn,        // System data pins in
	input  wire logic                          sysParityLineIn,     // System parity pin in
	output logic      [dbsws_pkg::BYTE_W-1:0]  sysDataBusOut,       // System data pins out
	output logic                               sysParityLineOut,    // System parity pin out
	output logic                               sysDriveEn,          // System pins driven
	output logic                               writeReady           // Write buffer has room
);

	// Storage array, no reset
	logic [dbsws_pkg::WORD_W-1:0] array [dbsws_pkg::ARRAY_SIZE];

	// Words as seen on the two buses, parity in the top bit
	logic [dbsws_pkg::WORD_W-1:0] procWord;
	logic [dbsws_pkg::WORD_W-1:0] sysWord;
	logic [dbsws_pkg::WORD_W-1:0] readWord;

	// Cycle decode
	logic                         procCapture;
	logic                         sysCapture;
	logic                         writeCycle;
	logic                         floatCycle;
	logic                         readCycle;
	logic [dbsws_pkg::WORD_W-1:0] writeWord;

	// Output latch state
	logic [dbsws_pkg::WORD_W-1:0] procQ;
	logic [dbsws_pkg::WORD_W-1:0] sysQ;
	logic                         procEnSeen;
	logic                         sysEnSeen;
	logic [dbsws_pkg::WORD_W-1:0] next_procQ;
	logic [dbsws_pkg::WORD_W-1:0] next_sysQ;
	logic                         next_floated;
	logic                         next_procEnSeen;
	logic                         next_sysEnSeen;
	logic                         next_procDriveEn;
	logic                         next_sysDriveEn;

	// Write buffer ports
	logic                                    bufInReady;
	logic                                    bufOutValid;
	logic                                    bufOutReady;
	logic [dbsws_pkg::ENTRY_W-1:0]           bufInData;
	logic [dbsws_pkg::ENTRY_W-1:0]           bufOutData;
	logic [dbsws_pkg::ADDR_W-1:0]            drainAddr;
	logic [dbsws_pkg::WORD_W-1:0]            drainWord;

	// Write engine state
	dbsws_pkg::dbsws_wr_e                    wrState;
	dbsws_pkg::dbsws_wr_e                    next_wrState;
	logic [dbsws_pkg::BUSY_W-1:0]            busyCount;
	logic [dbsws_pkg::BUSY_W-1:0]            next_busyCount;
	logic                                    arrayWrite;

	assign procWord = {procParityLineIn, procDataBusIn};
	assign sysWord  = {sysParityLineIn, sysDataBusIn};
	assign readWord = array[addr];

	// Classify the cycle from the strobes sampled at this edge
	always_comb begin
		procCapture = !procInputEnableN;
		sysCapture  = !sysInputEnableN;
		readCycle   = writeStrobeN;
		writeCycle  = !writeStrobeN && (procCapture || sysCapture);
		floatCycle  = !writeStrobeN && !procCapture && !sysCapture;
		// processor word wins if both are captured; the outcome is not defined
		writeWord   = procCapture ? procWord : sysWord;
		bufInData   = {addr, writeWord};
	end

	// Output latches: next word for each bus and the float flag
	always_comb begin
		next_procQ   = procQ;
		next_sysQ    = sysQ;
		next_floated = 1'b0;
		if (writeCycle) begin
			// streaming write onto the far bus
			if (procCapture) begin
				next_sysQ = procWord;
			end
			if (sysCapture) begin
				next_procQ = sysWord;
			end
		end else if (floatCycle) begin
			// both buses float after this edge
			next_floated = 1'b1;
		end else if (readCycle) begin
			// read word onto each bus whose far bus is not capturing
			next_procQ = readWord;
			next_sysQ  = readWord;
			if (procCapture) begin
				next_sysQ = procWord;
			end
			if (sysCapture) begin
				next_procQ = sysWord;
			end
		end
	end

	// Drive enables: turn-off takes one edge, turn-on two, so a swap never overlaps
	always_comb begin
		next_procEnSeen  = !procOutputEnableN;
		next_sysEnSeen   = !sysOutputEnableN;
		next_procDriveEn = !procOutputEnableN && procEnSeen && !next_floated;
		next_sysDriveEn  = !sysOutputEnableN && sysEnSeen && !next_floated;
	end

	// outputs move only at the rising edge
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			procQ       <= dbsws_pkg::WORD_RESET;
			sysQ        <= dbsws_pkg::WORD_RESET;
			procEnSeen  <= 1'b0;
			sysEnSeen   <= 1'b0;
			procDriveEn <= 1'b0;
			sysDriveEn  <= 1'b0;
		end else begin
			procQ       <= next_procQ;
			sysQ        <= next_sysQ;
			procEnSeen  <= next_procEnSeen;
			sysEnSeen   <= next_sysEnSeen;
			procDriveEn <= next_procDriveEn;
			sysDriveEn  <= next_sysDriveEn;
		end
	end

	// Pin outputs come straight from the latch flops
	assign procDataBusOut    = procQ[dbsws_pkg::BYTE_W-1:0];
	assign procParityLineOut = procQ[dbsws_pkg::WORD_W-1];
	assign sysDataBusOut     = sysQ[dbsws_pkg::BYTE_W-1:0];
	assign sysParityLineOut  = sysQ[dbsws_pkg::WORD_W-1];

	// Captured writes queue here while the array finishes a self-timed write
	dbsws_fifo #(
		.WIDTH (dbsws_pkg::ENTRY_W),
		.DEPTH (dbsws_pkg::FIFO_DEPTH)
	) writeBuffer (
		.clk      (clk),
		.rst      (rst),
		.inValid  (writeCycle),
		.inReady  (bufInReady),
		.inData   (bufInData),
		.outValid (bufOutValid),
		.outReady (bufOutReady),
		.outData  (bufOutData)
	);

	// Registered inside the buffer, so the port stays a flop output
	assign writeReady = bufInReady;
	assign drainAddr  = bufOutData[dbsws_pkg::ENTRY_W-1:dbsws_pkg::WORD_W];
	assign drainWord  = bufOutData[dbsws_pkg::WORD_W-1:0];

	// Write engine: one array write occupies the array for the self-timed write time.
	// Back-to-back writes outrun it, which is what fills the buffer.
	always_comb begin
		next_wrState   = wrState;
		next_busyCount = busyCount;
		bufOutReady    = 1'b0;
		unique case (wrState)
			dbsws_pkg::WR_IDLE: begin
				bufOutReady = bufOutValid;
				if (bufOutValid && (dbsws_pkg::BUSY_LOAD != dbsws_pkg::BUSY_ZERO)) begin
					next_wrState   = dbsws_pkg::WR_BUSY;
					next_busyCount = dbsws_pkg::BUSY_LOAD;
				end
			end
			dbsws_pkg::WR_BUSY: begin
				next_busyCount = dbsws_pkg::BUSY_W'(busyCount - 1'b1);
				if (busyCount == dbsws_pkg::BUSY_W'(1)) begin
					next_wrState = dbsws_pkg::WR_IDLE;
				end
			end
			default: begin
				next_wrState   = dbsws_pkg::WR_IDLE;
				next_busyCount = dbsws_pkg::BUSY_ZERO;
			end
		endcase
		arrayWrite = bufOutReady;
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			wrState   <= dbsws_pkg::WR_IDLE;
			busyCount <= dbsws_pkg::BUSY_ZERO;
		end else begin
			wrState   <= next_wrState;
			busyCount <= next_busyCount;
		end
	end

	// array store of a drained write
	always_ff @(posedge clk) begin
		if (arrayWrite) begin
			array[drainAddr] <= drainWord;
		end
	end

endmodule

//--- dbsws_sram_chk.sv
`timescale 1ns/1ps
module dbsws_sram_chk (
	input wire logic                         clk,               // Clock
	input wire logic                         rst,               // Reset
	input wire logic                         writeStrobeN,      // Strobe
	input wire logic                         procInputEnableN,  // P capture
	input wire logic                         sysInputEnableN,   // S capture
	input wire logic                         procOutputEnableN, // P drive
	input wire logic                         sysOutputEnableN,  // S drive
	input wire logic [dbsws_pkg::BYTE_W-1:0] procDataBusIn,     // P in
	input wire logic                         procParityLineIn,  // P in
	input wire logic [dbsws_pkg::BYTE_W-1:0] procDataBusOut,    // P latch
	input wire logic                         procParityLineOut, // P latch
	input wire logic                         procDriveEn,       // P driven
	input wire logic [dbsws_pkg::BYTE_W-1:0] sysDataBusIn,      // S in
	input wire logic                         sysParityLineIn,   // S in
	input wire logic [dbsws_pkg::BYTE_W-1:0] sysDataBusOut,     // S latch
	input wire logic                         sysParityLineOut,  // S latch
	input wire logic                         sysDriveEn         // S driven
);
	logic fromP;
	logic fromS;
	logic flt;
	// Capture side and float cycle seen at an edge
	assign fromP = !procInputEnableN && sysInputEnableN;
	assign fromS = procInputEnableN && !sysInputEnableN;
	assign flt   = !writeStrobeN && procInputEnableN && sysInputEnableN;
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);
	sequence pOn;
		!procOutputEnableN && !flt;
	endsequence
	sequence sOn;
		!sysOutputEnableN && !flt;
	endsequence
	float_off_a: assert property (flt |=> !procDriveEn && !sysDriveEn)
		else $error("bus driven after float cycle");
	proc_off_a: assert property (procOutputEnableN |=> !procDriveEn)
		else $error("proc bus not released");
	sys_off_a: assert property (sysOutputEnableN |=> !sysDriveEn)
		else $error("sys bus not released");
	proc_on_a: assert property (pOn ##1 pOn |=> procDriveEn)
		else $error("proc bus not driven");
	sys_on_a: assert property (sOn ##1 sOn |=> sysDriveEn)
		else $error("sys bus not driven");
	proc_stream_a: assert property (!writeStrobeN && fromP |=>
		{sysParityLineOut, sysDataBusOut} == $past({procParityLineIn, procDataBusIn})
		&& $stable({procParityLineOut, procDataBusOut}))
		else $error("proc write not streamed");
	sys_stream_a: assert property (!writeStrobeN && fromS |=>
		{procParityLineOut, procDataBusOut} == $past({sysParityLineIn, sysDataBusIn})
		&& $stable({sysParityLineOut, sysDataBusOut}))
		else $error("sys write not streamed");
	pass_thru_a: assert property (writeStrobeN && fromP |=>
		{sysParityLineOut, sysDataBusOut} == $past({procParityLineIn, procDataBusIn}))
		else $error("proc word not passed");
endmodule
bind dbsws_sram dbsws_sram_chk u_chk (
	.clk, .rst, .writeStrobeN, .procInputEnableN, .sysInputEnableN,
	.procOutputEnableN, .sysOutputEnableN, .procDataBusIn, .procParityLineIn,
	.procDataBusOut, .procParityLineOut, .procDriveEn, .sysDataBusIn,
	.sysParityLineIn, .sysDataBusOut, .sysParityLineOut, .sysDriveEn
);

//--- dbsws_bus_model.sv
`timescale 1ns/1ps
module dbsws_bus_model (
	input  wire logic       clk,   // Clock
	input  wire logic [8:0] pWord, // P master word
	input  wire logic       pEn,   // P master drives
	input  wire logic [8:0] sWord, // S master word
	input  wire logic       sEn,   // S master drives
	input  wire logic [8:0] pOut,  // Device P word
	input  wire logic       pDrv,  // Device drives P
	input  wire logic [8:0] sOut,  // Device S word
	input  wire logic       sDrv,  // Device drives S
	output logic      [8:0] pWire, // P bus level
	output logic      [8:0] sWire, // S bus level
	output logic            clash  // Two drivers
);
	logic [8:0] pLast = 9'h000;
	logic [8:0] sLast = 9'h000;
	// Undriven bus toggles, so a stale word never looks valid
	always @(posedge clk) begin
		pLast <= pWire;
		sLast <= sWire;
	end
	// levels change with master updates away from the edge, and with device outputs and the undriven toggle at the edge
	always_comb begin
		pWire = pDrv ? pOut : (pEn ? pWord : ~pLast);
		sWire = sDrv ? sOut : (sEn ? sWord : ~sLast);
	end
	assign clash = (pDrv && pEn) || (sDrv && sEn);
endmodule

//--- dual_bus_sram_write_stream_bench.sv
`timescale 1ns/1ps
module dual_bus_sram_write_stream_bench;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic [16:0] addr = 17'h00000;
	logic        strobeN = 1'b1;
	logic        procInEnN = 1'b1;
	logic        sysInEnN = 1'b1;
	logic        procOutEnN = 1'b1;
	logic        sysOutEnN = 1'b1;
	logic        pEn = 1'b0;
	logic        sEn = 1'b0;
	logic [8:0]  pWord = 9'h000;
	logic [8:0]  sWord = 9'h000;
	logic [8:0]  pWire, sWire;
	// Two output ports drive parts of each word, so these are nets
	wire  [8:0]  pOut, sOut;
	logic        pDrv, sDrv, ready, clash;
	int          err_count = 0;
	int          compares = 0;
	// Core clock, 10 ns period
	always #5 clk = ~clk;
	dbsws_sram u_dut (.clk(clk), .rst(rst), .addr(addr), .writeStrobeN(strobeN),
		.procInputEnableN(procInEnN), .sysInputEnableN(sysInEnN),
		.procOutputEnableN(procOutEnN), .sysOutputEnableN(sysOutEnN),
		.procDataBusIn(pWire[7:0]), .procParityLineIn(pWire[8]),
		.procDataBusOut(pOut[7:0]), .procParityLineOut(pOut[8]), .procDriveEn(pDrv),
		.sysDataBusIn(sWire[7:0]), .sysParityLineIn(sWire[8]), .sysDataBusOut(sOut[7:0]),
		.sysParityLineOut(sOut[8]), .sysDriveEn(sDrv), .writeReady(ready));
	dbsws_bus_model u_bus (.clk(clk), .pWord(pWord), .pEn(pEn), .sWord(sWord),
		.sEn(sEn), .pOut(pOut), .pDrv(pDrv), .sOut(sOut), .sDrv(sDrv),
		.pWire(pWire), .sWire(sWire), .clash(clash));
	task automatic checkWord(input string what, input logic [8:0] exp, input logic [8:0] got);
		compares++;
		if (got !== exp) begin
			err_count++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic checkBit(input string what, input logic exp, input logic got);
		compares++;
		if (got !== exp) begin
			err_count++;
			$display("Error %s expected %b seen %b", what, exp, got);
		end
	endtask
	task automatic complete_run();
		$display("Compares %0d errors %0d", compares, err_count);
		if (err_count == 0 && compares > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	// Quiet read cycle, masters off
	task automatic idle();
		strobeN = 1'b1;
		procInEnN = 1'b1;
		sysInEnN = 1'b1;
		pEn = 1'b0;
		sEn = 1'b0;
	endtask
	task automatic readWord(input logic [16:0] a, input logic [8:0] exp);
		@(negedge clk);
		idle();
		addr = a;
		@(negedge clk);
		checkWord("proc read", exp, pOut);
		checkWord("sys read", exp, sOut);
	endtask
	task automatic writeWord(input logic [16:0] a, input logic [8:0] w, input logic fromP);
		@(negedge clk);
		addr = a;
		strobeN = 1'b0;
		procInEnN = !fromP;
		sysInEnN = fromP;
		pWord = w;
		sWord = w;
		pEn = fromP;
		sEn = !fromP;
		@(negedge clk);
		checkWord("stream word", w, fromP ? sOut : pOut);
		idle();
	endtask
	task automatic scenWriteRead();
		writeWord(17'h00001, 9'h1A5, 1'b1);
		writeWord(17'h1FFFF, 9'h05A, 1'b0);
		repeat (8) @(negedge clk);
		readWord(17'h00001, 9'h1A5);
		readWord(17'h1FFFF, 9'h05A);
	endtask
	task automatic scenFloat();
		writeWord(17'h00010, 9'h0F0, 1'b1);
		@(negedge clk);
		strobeN = 1'b0;
		pWord = 9'h10F;
		pEn = 1'b1;
		@(negedge clk);
		idle();
		repeat (8) @(negedge clk);
		readWord(17'h00010, 9'h0F0);
	endtask
	task automatic scenPass();
		@(negedge clk);
		procInEnN = 1'b0;
		pWord = 9'h133;
		pEn = 1'b1;
		@(negedge clk);
		checkWord("pass to sys", 9'h133, sOut);
		// Swap capture side; each pin is set once in this time step
		procInEnN = 1'b1;
		pEn = 1'b0;
		sysInEnN = 1'b0;
		sWord = 9'h0CC;
		sEn = 1'b1;
		@(negedge clk);
		checkWord("pass to proc", 9'h0CC, pOut);
		idle();
	endtask
	task automatic scenOe();
		@(negedge clk);
		procOutEnN = 1'b0;
		sysOutEnN = 1'b0;
		@(negedge clk);
		checkBit("proc drive early", 1'b0, pDrv);
		@(negedge clk);
		checkBit("proc drive on", 1'b1, pDrv);
		checkBit("sys drive on", 1'b1, sDrv);
		procOutEnN = 1'b1;
		@(negedge clk);
		checkBit("proc drive off", 1'b0, pDrv);
		checkBit("sys drive kept", 1'b1, sDrv);
		checkBit("bus clash", 1'b0, clash);
		strobeN = 1'b0;
		@(negedge clk);
		checkBit("sys float", 1'b0, sDrv);
		idle();
		sysOutEnN = 1'b1;
	endtask
	// Back-to-back writes outrun the array until the buffer refuses
	task automatic scenFill();
		int n;
		logic full;
		n = 0;
		full = 1'b0;
		for (int i = 0; i < 40; i++) begin
			@(negedge clk);
			if (ready === 1'b1) begin
				addr = 17'h00200 + 17'(n);
				strobeN = 1'b0;
				procInEnN = 1'b0;
				pWord = 9'(n) ^ 9'h155;
				pEn = 1'b1;
				n++;
			end else begin
				strobeN = 1'b1;
				full = 1'b1;
			end
		end
		@(negedge clk);
		idle();
		checkBit("buffer refused", 1'b1, full);
		repeat (40) @(negedge clk);
		checkBit("buffer drained", 1'b1, ready);
		for (int i = 0; i < n; i++) begin
			readWord(17'h00200 + 17'(i), 9'(i) ^ 9'h155);
		end
	endtask
	initial begin
		repeat (8) @(negedge clk);
		rst = 1'b0;
		checkBit("ready after reset", 1'b1, ready);
		scenWriteRead();
		scenFloat();
		scenPass();
		scenOe();
		scenFill();
		complete_run();
	end
endmodule
